// file: shared/gcrd_pkg.sv
// Package: register map, reset values and timing constants of the gauge block
package gcrd_pkg;
    // Register offsets on the host register port
    localparam logic [7:0] ADDR_AVAIL_HI   = 8'h03;
    localparam logic [7:0] ADDR_LEARNED    = 8'h05;
    localparam logic [7:0] ADDR_CPI        = 8'h09;
    localparam logic [7:0] ADDR_DMF        = 8'h0a;
    localparam logic [7:0] ADDR_AVAIL_LO   = 8'h17;
    localparam logic [7:0] ADDR_SOFT_RST   = 8'h39;

    // Reset values and soft reset codes
    localparam logic [7:0]  DMF_RESET      = 8'h00;
    localparam logic [7:0]  SOFT_RST_IDLE  = 8'h00;
    localparam logic [7:0]  SOFT_RST_FIRE  = 8'h80;
    localparam logic [15:0] AVAIL_RESET    = 16'h0000;
    localparam logic [7:0]  CPI_RESET      = 8'h00;
    localparam logic [7:0]  CPI_MAX        = 8'hff;
    localparam logic [7:0]  CPI_STALE      = 8'h40;
    localparam logic [12:0] SELFDIS_LIMIT  = 13'h1000;

    // Temperature codes: 0 C lower bound and -20 C lower bound
    localparam logic [3:0]  TEMP_CODE_0C   = 4'h4;
    localparam logic [3:0]  TEMP_CODE_M20C = 4'h2;

    // High-charge ratio 0.94 = 47/50
    localparam logic [7:0]  RATIO_NUM      = 8'h2f;
    localparam logic [7:0]  RATIO_DEN      = 8'h32;

    // Display timing
    localparam int CLK_PERIOD_NS    = 5;
    localparam int BANK_PERIOD_NS   = 10_000_000;
    localparam int BLINK_PERIOD_NS  = 250_000_000;
    localparam int BANK_ON_PCT      = 30;
    localparam int BANK_PERIOD_CYC  = BANK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BLINK_HALF_CYC   = BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [4:0] BANK_A_MASK = 5'h15;
    localparam logic [4:0] BANK_B_MASK = 5'h0a;
endpackage

// file: rtl/gcrd_sync.sv
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module gcrd_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    ////////////////////////////////////////////////////////////////////////
    // A bit moves only once stages two and three agree
    always_comb
    begin
        lvl_d = lvl_q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                lvl_d[i] = s2_q[i];
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end
        else
        begin
            s1_q  <= i_pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule
`default_nettype wire

// file: rtl/gcrd_display.sv
// Relative-mode five-segment LED display with bank multiplexing and blink
`timescale 1ns/10ps
`default_nettype none
module gcrd_display #(
    parameter int BANK_CYC  = gcrd_pkg::BANK_PERIOD_CYC,
    parameter int BLINK_CYC = gcrd_pkg::BLINK_HALF_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_avail_hi,
    input  wire logic [7:0] i_learned,
    input  wire logic [3:0] i_temp_code,
    input  wire logic       i_display_request_n_low,
    input  wire logic       i_display_request_n_high,
    input  wire logic       i_counting,
    input  wire logic       i_charge_detect,
    input  wire logic       i_first_empty,
    input  wire logic       i_final_empty,
    output logic      [4:0] o_led_segment_outputs
);
    localparam logic [31:0] ON_CYC   = 32'(BANK_CYC * gcrd_pkg::BANK_ON_PCT / 100);
    localparam logic [31:0] HALF_CYC = 32'(BANK_CYC / 2);

    logic [31:0] phase_q, phase_d, blink_cnt_q, blink_cnt_d;
    logic        blink_q, blink_d;
    logic [4:0]  seg_q, seg_d, level;
    logic [9:0]  adj;
    logic        active, bank_a, bank_b;

    ////////////////////////////////////////////////////////////////////////
    // Cold correction touches only what is shown, never the count itself
    always_comb
    begin
        if (i_temp_code >= gcrd_pkg::TEMP_CODE_0C)
            adj = {2'b00, i_avail_hi};
        else if (i_temp_code >= gcrd_pkg::TEMP_CODE_M20C)
            adj = 10'(({2'b00, i_avail_hi} + {1'b0, i_avail_hi, 1'b0}) >> 2);
        else
            adj = {3'b000, i_avail_hi[7:1]};
    end

    // Segment k lights for any part of the k-th fifth of learned capacity
    for (genvar k = 0; k < 5; k++)
    begin : g_level
        assign level[k] = (12'(adj) * 12'h005) > (12'(i_learned) * 12'(k));
    end

    ////////////////////////////////////////////////////////////////////////
    assign bank_a = phase_q < ON_CYC;
    assign bank_b = (phase_q >= HALF_CYC) && (phase_q < HALF_CYC + ON_CYC);
    assign active = !i_final_empty && !i_display_request_n_high &&
                    (i_display_request_n_low || i_counting || i_charge_detect);

    always_comb
    begin
        phase_d     = (phase_q == 32'(BANK_CYC - 1)) ? 32'h0 : phase_q + 32'h1;
        blink_cnt_d = blink_cnt_q + 32'h1;
        blink_d     = blink_q;
        if (blink_cnt_q == 32'(BLINK_CYC - 1))
        begin
            blink_cnt_d = 32'h0;
            blink_d     = !blink_q;
        end
        seg_d = '0;
        if (active)
        begin
            seg_d = level & ((bank_a ? gcrd_pkg::BANK_A_MASK : 5'h00) |
                             (bank_b ? gcrd_pkg::BANK_B_MASK : 5'h00));
            if (i_first_empty)
                seg_d[0] = bank_a && blink_q;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            phase_q     <= 32'h0;
            blink_cnt_q <= 32'h0;
            blink_q     <= 1'b0;
            seg_q       <= 5'h00;
        end
        else
        begin
            phase_q     <= phase_d;
            blink_cnt_q <= blink_cnt_d;
            blink_q     <= blink_d;
            seg_q       <= seg_d;
        end
    end

    assign o_led_segment_outputs = seg_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_display_request_n_high_off: assert property (i_display_request_n_high |=> seg_q == 5'h00)
        else $error("segments lit while display request held high");
    a_final_empty_off: assert property (i_final_empty |=> seg_q == 5'h00)
        else $error("segments lit while final empty set");
    a_banks_apart: assert property (!((|(seg_q & gcrd_pkg::BANK_A_MASK)) && (|(seg_q & gcrd_pkg::BANK_B_MASK))))
        else $error("both segment banks lit together");
    a_display_request_n_low_on: assert property (i_display_request_n_low && !i_final_empty && !i_display_request_n_high && !i_first_empty
                                    && bank_a && level[0] |=> seg_q[0])
        else $error("display request low did not light segment one");
endmodule
`default_nettype wire

// file: rtl/gcrd_top.sv
// Gas gauge core: charge count, learned capacity, stale counter, soft reset, display
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Learn capacity only on qualified full-to-empty discharge
// - Count up on each valid charge
// - Above 0.94 capacity, count only first charge
// - Counter saturates at 255, never wraps
// - Reaching 64 sets capacity-stale flag
// - Capacity learn clears counter and stale flag
// - Host writes filter setting, sets thresholds
// - Writing 00h then 80h resets gauge
// - Reset loads capacity, zeroes counts, sets stale and replaced flags, clears qualified flag
// - Program input five high stops self-discharge
// - Each segment shows 20% of capacity
// - Temperature correction affects only displayed level
// - Display request high keeps segments dark
// - Floating request: show while counting or charging
// - Display request low lights segments at once
// - Segments one/three/five alternate with two/four
// - Banks modulate near 100Hz, 30% each
// - First empty blinks segment one at 4Hz
// - Final empty switches the display off
// - Charge counts up, discharges count down
module gcrd_top #(
    parameter int BANK_PERIOD_CYC = gcrd_pkg::BANK_PERIOD_CYC,
    parameter int BLINK_HALF_CYC  = gcrd_pkg::BLINK_HALF_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic [7:0] i_programmed_full_capacity,
    input  wire logic       i_charge_pulse,
    input  wire logic       i_discharge_pulse,
    input  wire logic       i_selfdis_pulse,
    input  wire logic       i_valid_charge,
    input  wire logic       i_counting,
    input  wire logic       i_charge_detect,
    input  wire logic       i_first_empty_flag,
    input  wire logic       i_final_empty_flag,
    input  wire logic [3:0] i_temp_code,
    input  wire logic       i_program_input_five,
    input  wire logic       i_display_request_low,
    input  wire logic       i_display_request_high,
    output logic      [7:0] o_magnitude_filter_setting,
    output logic            o_capacity_stale_flag,
    output logic            o_battery_replaced_flag,
    output logic            o_discharge_qualified_flag,
    output logic      [4:0] o_led_segment_outputs
);
    logic [2:0]  pins_s;
    logic        program_input_five_s, display_request_n_low_s, display_request_n_high_s;

    logic [15:0] avail_q, avail_d, dis_cnt_q, dis_cnt_d;
    logic [7:0]  learned_q, learned_d, cpi_q, cpi_d;
    logic        stale_q, stale_d, brp_q, brp_d, vdq_q, vdq_d, gate_q, gate_d, empty_prev_q;
    logic [12:0] selfdis_q, selfdis_d;

    logic [7:0]  dmf_q, dmf_d, rst_reg_q, rst_reg_d, rdata_q, rdata_d;
    logic        soft_rst_q, soft_rst_d;

    logic        full, empty_rise, learn, above_ratio, below_ratio, dis_event, chg_event;
    logic [23:0] avail_scaled, learned_scaled;

    ////////////////////////////////////////////////////////////////////////
    gcrd_sync #(
        .W (3)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     ({i_program_input_five, i_display_request_low, i_display_request_high}),
        .o_level   (pins_s)
    );
    assign program_input_five_s     = pins_s[2];
    assign display_request_n_low_s  = pins_s[1];
    assign display_request_n_high_s = pins_s[0];

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        return addr == reg_addr;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Gauge decisions
    assign full           = (avail_q[15:8] == learned_q) && (learned_q != 8'h00);
    assign empty_rise     = i_first_empty_flag && !empty_prev_q;
    assign learn          = empty_rise && vdq_q && (i_temp_code >= gcrd_pkg::TEMP_CODE_0C)
                            && (selfdis_q < gcrd_pkg::SELFDIS_LIMIT);
    assign avail_scaled   = 24'(avail_q) * 24'(gcrd_pkg::RATIO_DEN);
    assign learned_scaled = 24'({learned_q, 8'h00}) * 24'(gcrd_pkg::RATIO_NUM);
    assign above_ratio    = avail_scaled > learned_scaled;
    assign below_ratio    = avail_scaled < learned_scaled;
    assign chg_event      = i_charge_pulse;
    // Self-discharge is held off while the strap is high
    assign dis_event      = i_discharge_pulse || (i_selfdis_pulse && !program_input_five_s);

    always_comb
    begin
        avail_d   = avail_q;
        dis_cnt_d = dis_cnt_q;
        learned_d = learned_q;
        cpi_d     = cpi_q;
        stale_d   = stale_q;
        brp_d     = brp_q;
        vdq_d     = vdq_q;
        gate_d    = gate_q;
        selfdis_d = selfdis_q;

        // Arming at full; any valid charge breaks the learn cycle
        if (i_valid_charge)
            vdq_d = 1'b0;
        else if (full)
        begin
            vdq_d     = 1'b1;
            dis_cnt_d = 16'h0000;
            selfdis_d = 13'h0000;
        end

        // Charge wins when both directions pulse together below full; at full the discharge is taken
        // A discharge taken while still full is the first count of the cycle
        if (chg_event && (avail_q[15:8] < learned_q))
            avail_d = avail_q + 16'h0001;
        else if (dis_event && (avail_q != 16'h0000))
        begin
            avail_d   = avail_q - 16'h0001;
            dis_cnt_d = (dis_cnt_d == 16'hffff) ? dis_cnt_d : dis_cnt_d + 16'h0001;
        end
        if (i_selfdis_pulse && !program_input_five_s && (selfdis_d < gcrd_pkg::SELFDIS_LIMIT))
            selfdis_d = selfdis_d + 13'h0001;

        if (i_valid_charge)
        begin
            if (!above_ratio || gate_q)
            begin
                cpi_d = (cpi_q == gcrd_pkg::CPI_MAX) ? cpi_q : cpi_q + 8'h01;
                if (cpi_q + 8'h01 == gcrd_pkg::CPI_STALE)
                    stale_d = 1'b1;
            end
            if (above_ratio)
                gate_d = 1'b0;
        end
        if (below_ratio)
            gate_d = 1'b1;

        if (learn)
        begin
            learned_d = dis_cnt_q[15:8];
            cpi_d     = gcrd_pkg::CPI_RESET;
            stale_d   = 1'b0;
            vdq_d     = 1'b0;
        end

        // Host overwrites of the count and the learned capacity
        if (i_reg_wr && hit(i_reg_addr, gcrd_pkg::ADDR_AVAIL_HI))
            avail_d = {i_reg_wdata, 8'h00};
        if (i_reg_wr && hit(i_reg_addr, gcrd_pkg::ADDR_LEARNED))
            learned_d = i_reg_wdata;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || soft_rst_q)
        begin
            avail_q      <= gcrd_pkg::AVAIL_RESET;
            dis_cnt_q    <= 16'h0000;
            learned_q    <= i_programmed_full_capacity;
            cpi_q        <= gcrd_pkg::CPI_RESET;
            stale_q      <= 1'b1;
            brp_q        <= 1'b1;
            vdq_q        <= 1'b0;
            gate_q       <= 1'b1;
            selfdis_q    <= 13'h0000;
            empty_prev_q <= 1'b0;
        end
        else
        begin
            avail_q      <= avail_d;
            dis_cnt_q    <= dis_cnt_d;
            learned_q    <= learned_d;
            cpi_q        <= cpi_d;
            stale_q      <= stale_d;
            brp_q        <= brp_d;
            vdq_q        <= vdq_d;
            gate_q       <= gate_d;
            selfdis_q    <= selfdis_d;
            empty_prev_q <= i_first_empty_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port: read data one cycle after the read strobe
    always_comb
    begin
        dmf_d      = dmf_q;
        rst_reg_d  = rst_reg_q;
        soft_rst_d = 1'b0;
        rdata_d    = rdata_q;
        if (i_reg_wr && hit(i_reg_addr, gcrd_pkg::ADDR_DMF))
            dmf_d = i_reg_wdata;
        if (i_reg_wr && hit(i_reg_addr, gcrd_pkg::ADDR_SOFT_RST))
        begin
            rst_reg_d = i_reg_wdata;
            // Only the 00h to 80h step fires; other codes are the host's fault
            soft_rst_d = (rst_reg_q == gcrd_pkg::SOFT_RST_IDLE)
                         && (i_reg_wdata == gcrd_pkg::SOFT_RST_FIRE);
        end
        if (i_reg_rd)
        begin
            unique case (1'b1)
                hit(i_reg_addr, gcrd_pkg::ADDR_AVAIL_HI): rdata_d = avail_q[15:8];
                hit(i_reg_addr, gcrd_pkg::ADDR_AVAIL_LO): rdata_d = avail_q[7:0];
                hit(i_reg_addr, gcrd_pkg::ADDR_LEARNED):  rdata_d = learned_q;
                hit(i_reg_addr, gcrd_pkg::ADDR_CPI):      rdata_d = cpi_q;
                hit(i_reg_addr, gcrd_pkg::ADDR_DMF):      rdata_d = dmf_q;
                default:                                  rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            dmf_q      <= gcrd_pkg::DMF_RESET;
            rst_reg_q  <= gcrd_pkg::SOFT_RST_IDLE;
            soft_rst_q <= 1'b0;
            rdata_q    <= 8'h00;
        end
        else
        begin
            dmf_q      <= dmf_d;
            rst_reg_q  <= rst_reg_d;
            soft_rst_q <= soft_rst_d;
            rdata_q    <= rdata_d;
        end
    end

    assign o_reg_rdata                = rdata_q;
    assign o_magnitude_filter_setting = dmf_q;
    assign o_capacity_stale_flag      = stale_q;
    assign o_battery_replaced_flag    = brp_q;
    assign o_discharge_qualified_flag = vdq_q;

    ////////////////////////////////////////////////////////////////////////
    gcrd_display #(
        .BANK_CYC  (BANK_PERIOD_CYC),
        .BLINK_CYC (BLINK_HALF_CYC)
    ) u_display (
        .i_clk                 (i_clk),
        .i_sys_rst             (i_sys_rst),
        .i_avail_hi            (avail_q[15:8]),
        .i_learned             (learned_q),
        .i_temp_code           (i_temp_code),
        .i_display_request_n_low            (display_request_n_low_s),
        .i_display_request_n_high           (display_request_n_high_s),
        .i_counting            (i_counting),
        .i_charge_detect       (i_charge_detect),
        .i_first_empty         (i_first_empty_flag),
        .i_final_empty         (i_final_empty_flag),
        .o_led_segment_outputs (o_led_segment_outputs)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_plain_charge;
        i_valid_charge && !learn && !soft_rst_q && !(i_reg_wr && i_reg_addr == gcrd_pkg::ADDR_LEARNED);
    endsequence

    a_cpi_saturate: assert property (s_plain_charge and (cpi_q == gcrd_pkg::CPI_MAX) |=> cpi_q == gcrd_pkg::CPI_MAX)
        else $error("charge counter wrapped past 255");
    a_cpi_count: assert property (s_plain_charge and (!above_ratio && cpi_q != gcrd_pkg::CPI_MAX)
                                  |=> cpi_q == $past(cpi_q) + 8'h01)
        else $error("charge counter missed a valid charge");
    a_cpi_gate: assert property (s_plain_charge and (above_ratio && !gate_q) |=> $stable(cpi_q))
        else $error("charge counter moved above ratio");
    a_stale_set: assert property (s_plain_charge and (cpi_q == 8'h3f && (!above_ratio || gate_q))
                                  |=> cpi_q == 8'h40 && stale_q)
        else $error("stale flag not set at 64");
    a_learn_clear: assert property (learn && !soft_rst_q |=> cpi_q == 8'h00 && !stale_q)
        else $error("learn did not clear counter and stale flag");
    a_learn_cold: assert property (empty_rise && i_temp_code < gcrd_pkg::TEMP_CODE_0C && !soft_rst_q
                                   && !(i_reg_wr && i_reg_addr == gcrd_pkg::ADDR_LEARNED) |=> $stable(learned_q))
        else $error("capacity learned below zero degrees");
    a_dmf_write: assert property (i_reg_wr && i_reg_addr == gcrd_pkg::ADDR_DMF
                                  |=> o_magnitude_filter_setting == $past(i_reg_wdata))
        else $error("filter setting write lost");
    a_soft_reset: assert property (i_reg_wr && i_reg_addr == gcrd_pkg::ADDR_SOFT_RST && rst_reg_q == 8'h00
                                   && i_reg_wdata == 8'h80 ##1 1'b1 |=> avail_q == 16'h0000 && cpi_q == 8'h00
                                   && stale_q && brp_q && !vdq_q && learned_q == $past(i_programmed_full_capacity))
        else $error("soft reset did not restore gauge state");
    a_selfdis_off: assert property (program_input_five_s && i_selfdis_pulse && !i_discharge_pulse && !i_charge_pulse
                                    && !i_reg_wr && !soft_rst_q |=> $stable(avail_q))
        else $error("self-discharge counted with strap high");
endmodule
`default_nettype wire

// file: verif/gcrd_host_model.sv
// Host model: issues decoded register accesses as the serial link would
`timescale 1ns/10ps
`default_nettype none
module gcrd_host_model (
    input  wire logic       i_clk,
    output logic      [7:0] o_reg_addr,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic      [7:0] o_reg_wdata,
    output logic            o_rd_done
);
    initial
    begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_rd_done = 1'b0;
    end

    // Read data stands from the cycle after the read edge
    always @(posedge i_clk) o_rd_done <= o_reg_rd;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg_addr <= a;
        o_reg_wdata <= d;
        o_reg_wr <= 1'b1;
        @(posedge i_clk);
        o_reg_wr <= 1'b0;
        // Released lines show no stale value
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        o_reg_addr <= a;
        o_reg_rd <= 1'b1;
        @(posedge i_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// file: verif/gauge_count_reset_display_tb.sv
// Testbench: charge counter, soft reset and segment display
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module gauge_count_reset_display_tb;
    logic        i_clk, i_sys_rst, wr, rd_s, done, vchg, dis, cnt, fe1, fef, rlo, rhi, stale, repl, qual;
    logic        chg, sd, program_input_five, cdet;
    logic [7:0]  addr, wd, rdat, filt, d;
    logic [3:0]  temp;
    logic [4:0]  segs;
    logic [15:0] q[$], e;
    int          error_cnt, checked, seed, ca, cb;

    gcrd_host_model host_u (.i_clk(i_clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd_s),
        .o_reg_wdata(wd), .o_rd_done(done));
    // Short bank and blink periods keep the display scans brief
    gcrd_top #(.BANK_PERIOD_CYC(20), .BLINK_HALF_CYC(8)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd_s), .i_reg_wdata(wd), .o_reg_rdata(rdat),
        .i_programmed_full_capacity(8'h04), .i_charge_pulse(chg), .i_discharge_pulse(dis),
        .i_selfdis_pulse(sd), .i_valid_charge(vchg), .i_counting(cnt), .i_charge_detect(cdet),
        .i_first_empty_flag(fe1), .i_final_empty_flag(fef), .i_temp_code(temp), .i_program_input_five(program_input_five),
        .i_display_request_low(rlo), .i_display_request_high(rhi), .o_magnitude_filter_setting(filt),
        .o_capacity_stale_flag(stale), .o_battery_replaced_flag(repl), .o_discharge_qualified_flag(qual),
        .o_led_segment_outputs(segs));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    initial
    begin
        #100_000;
        error_cnt++;
        report_and_stop();
    end

    always @(negedge i_clk)
    begin
        if (done === 1'b1)
        begin
            e = q.pop_front();
            `CHK($sformatf("reg_%h", e[15:8]), e[7:0], rdat)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        q.push_back({a, x});
        host_u.rd(a);
    endtask

    // Events are spaced one idle cycle apart, one per charge
    task automatic ev(input int n, input logic [3:0] s);
        repeat (n)
        begin
            @(posedge i_clk);
            {chg, sd, vchg, dis} <= s;
            @(posedge i_clk);
            {chg, sd, vchg, dis} <= 4'h0;
        end
    endtask

    task automatic scan(input logic [4:0] a, input logic [4:0] b, input int na, input int nb);
        ca = 0;
        cb = 0;
        repeat (8) @(negedge i_clk);
        repeat (40)
        begin
            @(negedge i_clk);
            if (segs === a) ca++;
            else if (segs === b) cb++;
        end
        if (na >= 0)
        begin
            `CHK("bank_a", na, ca)
            `CHK("bank_b", nb, cb)
        end
        @(posedge i_clk);
    endtask

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 8;
        error_cnt = 0;
        checked = 0;
        i_sys_rst = 1'b1;
        {chg, sd, program_input_five, cdet, vchg, dis, cnt, fe1, fef, rlo, rhi} = 11'h000;
        temp = 4'h6;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        `CHK("stale", 1'b1, stale)
        `CHK("replaced", 1'b1, repl)
        `CHK("qualified", 1'b0, qual)
        rd(8'h09, 8'h00);
        rd(8'h05, 8'h04);
        rd(8'h03, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h3f, 8'h00);
        $display("Test done: reset values");
        repeat (3)
        begin
            d = 8'($random(seed));
            host_u.wr(8'h0a, d);
            @(negedge i_clk);
            `CHK("filter", d, filt)
            rd(8'h0a, d);
        end
        host_u.wr(8'h09, 8'h55);
        rd(8'h09, 8'h00);
        $display("Test done: filter setting");
        host_u.wr(8'h03, 8'h04);
        repeat (2) @(negedge i_clk);
        `CHK("qualified", 1'b1, qual)
        ev(512, 4'h1);
        // A cold empty edge must not learn; the warm one after it does
        temp <= 4'h3;
        fe1 <= 1'b1;
        @(posedge i_clk);
        {fe1, temp} <= 5'h06;
        @(posedge i_clk);
        fe1 <= 1'b1;
        repeat (3) @(negedge i_clk);
        `CHK("stale", 1'b0, stale)
        rd(8'h05, 8'h02);
        rd(8'h09, 8'h00);
        fe1 <= 1'b0;
        ev(3, 4'h2);
        rd(8'h09, 8'h01);
        ev(40, 4'h1);
        ev(62, 4'h2);
        rd(8'h09, 8'h3f);
        ev(1, 4'h2);
        repeat (2) @(negedge i_clk);
        `CHK("stale", 1'b1, stale)
        ev(200, 4'h2);
        rd(8'h09, 8'hff);
        $display("Test done: counter");
        host_u.wr(8'h39, 8'h00);
        host_u.wr(8'h39, 8'h80);
        repeat (3) @(negedge i_clk);
        `CHK("stale", 1'b1, stale)
        rd(8'h09, 8'h00);
        rd(8'h05, 8'h04);
        rd(8'h17, 8'h00);
        $display("Test done: soft reset");
        ev(3, 4'h8);
        // Strap passes the pin filter before the first self-discharge
        program_input_five <= 1'b1;
        repeat (6) @(posedge i_clk);
        ev(4, 4'h4);
        rd(8'h17, 8'h03);
        program_input_five <= 1'b0;
        repeat (6) @(posedge i_clk);
        ev(1, 4'h4);
        rd(8'h17, 8'h02);
        $display("Test done: strap and charge");
        rlo <= 1'b1;
        host_u.wr(8'h03, 8'h04);
        scan(5'h15, 5'h0a, 12, 12);
        temp <= 4'h0;
        scan(5'h05, 5'h02, 12, 12);
        rd(8'h03, 8'h04);
        temp <= 4'h6;
        host_u.wr(8'h03, 8'h01);
        scan(5'h01, 5'h02, 12, 12);
        ev(1, 4'h2);
        fe1 <= 1'b1;
        scan(5'h01, 5'h00, -1, -1);
        `CHK("blink", 1'b1, ca > 0 && ca < 12)
        fef <= 1'b1;
        scan(5'h00, 5'h00, 40, 0);
        {fe1, fef, rlo, rhi} <= 4'h1;
        scan(5'h00, 5'h00, 40, 0);
        {rhi, cnt} <= 2'b01;
        scan(5'h01, 5'h02, 12, 12);
        {cnt, cdet} <= 2'b01;
        scan(5'h01, 5'h02, 12, 12);
        cdet <= 1'b0;
        scan(5'h00, 5'h00, 40, 0);
        $display("Test done: display");
        report_and_stop();
    end
endmodule
`default_nettype wire
